// file: logic/aod_cfg.svh
// register offsets, field positions and reset values for the analog output registers
`ifndef AOD_CFG_SVH
`define AOD_CFG_SVH
`define AOD_OFS_CH0 12'h000
`define AOD_OFS_CH1 12'h004
`define AOD_OFS_CH2 12'h008
`define AOD_OFS_CH3 12'h00C
`define AOD_SIGN_BIT 15
`define AOD_MAG_HI 11
`define AOD_MAG_LO 1
`define AOD_CH_RESET 16'h0000
`define AOD_CODE_RESET 12'h000
`endif

// file: logic/aod_pkg.sv
// types shared by the analog output register block
package aod_pkg;
  typedef logic [15:0] aod_word_t;
  typedef logic [11:0] aod_code_t;
  typedef enum logic [0:0] {
    AOD_IDLE = 1'b0,
    AOD_ACCESS = 1'b1
  } aod_phase_t;
endpackage : aod_pkg

// file: logic/aod_regs.sv
// four-channel analog output register block behind an apb slave
// Overview of operation
// - four 16-bit registers, one per channel
// - register index n drives channel n
// - bit 15 sign, bits 1-11 magnitude
// - bit 0 never reaches the converter
// - bit 0 always reads back zero
// - bits 12 to 14 never reach converter
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "aod_cfg.svh"
module aod_regs
  import aod_pkg::*;
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter codes: bit 11 sign, bits 10:0 data
  output logic [11:0] dac_code0,
  output logic [11:0] dac_code1,
  output logic [11:0] dac_code2,
  output logic [11:0] dac_code3
);

  // phase of the current bus transfer
  aod_phase_t phase_r;
  aod_phase_t phase_nxt;

  // address decode of the live bus
  logic [2:0] dec;
  logic dec_valid;
  logic [1:0] idx;

  // request captured in the setup cycle
  logic [1:0] req_idx_r;
  logic [1:0] req_idx_nxt;
  logic req_hit_r;
  logic req_hit_nxt;
  logic req_write_r;
  logic req_write_nxt;

  // qualified bus strobes
  logic setup_cyc;
  logic access_cyc;
  logic wr_access;
  logic [3:0] wr_hit;

  // channel storage, one word per converter
  aod_word_t chan_r [4];
  aod_word_t chan_nxt [4];

  // converter codes, refreshed only by a completed write
  aod_code_t code_r [4];
  aod_code_t code_nxt [4];

  // read data and error, launched in the setup cycle
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;

  // map byte address to channel index, valid flag in bit 2
  function automatic logic [2:0] aod_decode(
    input logic [11:0] addr
  );
    logic [2:0] res;
    res = 3'h0;
    unique case (addr)
      `AOD_OFS_CH0: res = 3'h4;
      `AOD_OFS_CH1: res = 3'h5;
      `AOD_OFS_CH2: res = 3'h6;
      `AOD_OFS_CH3: res = 3'h7;
      default: res = 3'h0;
    endcase
    return res;
  endfunction : aod_decode

  // converter code from register: sign plus bits 11:1
  function automatic aod_code_t aod_to_code(
    input aod_word_t w
  );
    return {w[`AOD_SIGN_BIT], w[`AOD_MAG_HI:`AOD_MAG_LO]};
  endfunction : aod_to_code

  // byte-lane merge of write data into a stored word
  function automatic aod_word_t aod_merge(
    input aod_word_t old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    aod_word_t res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : aod_merge

  // read-back word: bit 0 forced low, upper half zero
  function automatic logic [31:0] aod_read_word(
    input aod_word_t w
  );
    return {16'h0000, w[`AOD_SIGN_BIT:`AOD_MAG_LO], 1'b0};
  endfunction : aod_read_word

  // index n selects converter channel n
  function automatic logic [3:0] aod_onehot(
    input logic [1:0] n
  );
    logic [3:0] res;
    res = 4'h0;
    res[n] = 1'b1;
    return res;
  endfunction : aod_onehot

  assign dec = aod_decode(paddr);
  assign dec_valid = dec[2];
  assign idx = dec[1:0];
  assign setup_cyc = psel & ~penable;
  assign access_cyc = psel & penable & (phase_r == AOD_ACCESS);
  assign wr_access = access_cyc & req_write_r & req_hit_r;
  assign wr_hit = wr_access ? aod_onehot(req_idx_r) : 4'h0;

  // a setup cycle arms the access phase; anything else returns to idle
  always_comb begin
    phase_nxt = AOD_IDLE;
    unique case (phase_r)
      AOD_IDLE: begin
        if (setup_cyc) begin
          phase_nxt = AOD_ACCESS;
        end
      end
      AOD_ACCESS: begin
        if (setup_cyc) begin
          phase_nxt = AOD_ACCESS;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= AOD_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // address and direction latched at setup so the access write cannot slip
  always_comb begin
    req_idx_nxt = req_idx_r;
    req_hit_nxt = req_hit_r;
    req_write_nxt = req_write_r;
    if (setup_cyc) begin
      req_idx_nxt = idx;
      req_hit_nxt = dec_valid;
      req_write_nxt = pwrite;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_idx_r <= 2'h0;
      req_hit_r <= 1'b0;
      req_write_r <= 1'b0;
    end else begin
      req_idx_r <= req_idx_nxt;
      req_hit_r <= req_hit_nxt;
      req_write_r <= req_write_nxt;
    end
  end

  // channel storage: only the addressed word changes on a write
  always_comb begin
    chan_nxt[0] = chan_r[0];
    chan_nxt[1] = chan_r[1];
    chan_nxt[2] = chan_r[2];
    chan_nxt[3] = chan_r[3];
    if (wr_hit[0]) begin
      chan_nxt[0] = aod_merge(chan_r[0], pwdata, pstrb);
    end
    if (wr_hit[1]) begin
      chan_nxt[1] = aod_merge(chan_r[1], pwdata, pstrb);
    end
    if (wr_hit[2]) begin
      chan_nxt[2] = aod_merge(chan_r[2], pwdata, pstrb);
    end
    if (wr_hit[3]) begin
      chan_nxt[3] = aod_merge(chan_r[3], pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_r[0] <= `AOD_CH_RESET;
      chan_r[1] <= `AOD_CH_RESET;
      chan_r[2] <= `AOD_CH_RESET;
      chan_r[3] <= `AOD_CH_RESET;
    end else begin
      chan_r[0] <= chan_nxt[0];
      chan_r[1] <= chan_nxt[1];
      chan_r[2] <= chan_nxt[2];
      chan_r[3] <= chan_nxt[3];
    end
  end

  // converter codes follow the stored word only when a write completes
  always_comb begin
    code_nxt[0] = code_r[0];
    code_nxt[1] = code_r[1];
    code_nxt[2] = code_r[2];
    code_nxt[3] = code_r[3];
    if (wr_hit[0]) begin
      code_nxt[0] = aod_to_code(chan_nxt[0]);
    end
    if (wr_hit[1]) begin
      code_nxt[1] = aod_to_code(chan_nxt[1]);
    end
    if (wr_hit[2]) begin
      code_nxt[2] = aod_to_code(chan_nxt[2]);
    end
    if (wr_hit[3]) begin
      code_nxt[3] = aod_to_code(chan_nxt[3]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_r[0] <= `AOD_CODE_RESET;
      code_r[1] <= `AOD_CODE_RESET;
      code_r[2] <= `AOD_CODE_RESET;
      code_r[3] <= `AOD_CODE_RESET;
    end else begin
      code_r[0] <= code_nxt[0];
      code_r[1] <= code_nxt[1];
      code_r[2] <= code_nxt[2];
      code_r[3] <= code_nxt[3];
    end
  end

  // read data launched in the setup cycle, held through the access cycle
  always_comb begin
    prdata_nxt = prdata_r;
    if (setup_cyc) begin
      prdata_nxt = 32'h0000_0000;
      if (!pwrite && dec_valid) begin
        unique case (idx)
          2'h0: prdata_nxt = aod_read_word(chan_r[0]);
          2'h1: prdata_nxt = aod_read_word(chan_r[1]);
          2'h2: prdata_nxt = aod_read_word(chan_r[2]);
          2'h3: prdata_nxt = aod_read_word(chan_r[3]);
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // unmapped address flags an error in the access cycle, registered from the setup cycle
  always_comb begin
    pslverr_nxt = 1'b0;
    if (setup_cyc) begin
      pslverr_nxt = ~dec_valid;
    end else if (access_cyc) begin
      pslverr_nxt = pslverr_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= pslverr_nxt;
    end
  end

  // outputs
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign dac_code0 = code_r[0];
  assign dac_code1 = code_r[1];
  assign dac_code2 = code_r[2];
  assign dac_code3 = code_r[3];

endmodule : aod_regs
`default_nettype wire

// file: tb/aod_chk.sv
// checker for the channel registers
`timescale 1ns/10ps
`default_nettype none
module aod_chk(input wire logic pclk,presetn,psel,penable,pwrite,pready,pslverr,
  input wire logic [3:0] pstrb,input wire logic [11:0] paddr,dac_code0,dac_code1,
  dac_code2,dac_code3,input wire logic [31:0] pwdata,prdata);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr=psel&penable&pwrite;
  wire logic wf=wr&(pstrb[1:0]==2'h3);
  property p_ch0; logic [11:0] v;
    (wf&&paddr==0,v={pwdata[15],pwdata[11:1]}) |=> dac_code0==v; endproperty
  a_ch0: assert property(p_ch0) else $error("ch0 code wrong");
  property p_ch3; logic [11:0] v;
    (wf&&paddr==12,v={pwdata[15],pwdata[11:1]}) |=> dac_code3==v; endproperty
  a_ch3: assert property(p_ch3) else $error("ch3 code wrong");
  property p_hold; !wr |=> $stable(dac_code1)&&$stable(dac_code2); endproperty
  a_hold: assert property(p_hold) else $error("code moved idle");
  property p_iso; wr&&paddr==0 |=> $stable(dac_code3); endproperty
  a_iso: assert property(p_iso) else $error("other channel moved");
  property p_rd; psel&&penable&&!pwrite |-> prdata[0]==0; endproperty
  a_rd: assert property(p_rd) else $error("bit 0 read high");
  property p_err; psel&&penable&&paddr>12'h00C |-> pslverr; endproperty
  a_err: assert property(p_err) else $error("unmapped not flagged");
  property p_rdy; psel&&penable |-> pready; endproperty
  a_rdy: assert property(p_rdy) else $error("access not completed");
  cover property(wr&&paddr==0);
  cover property(wr&&paddr==12);
  cover property(psel&&penable&&!pwrite);
endmodule : aod_chk
bind aod_regs aod_chk aod_chk_i(.*);
`default_nettype wire

// file: tb/aod_proc.sv
// processor-side apb master model
`timescale 1ns/10ps
`default_nettype none
module aod_proc(input wire logic pclk,pready,input wire logic [31:0] prdata,
  output logic psel,penable,pwrite,output logic [11:0] paddr,output logic [31:0] pwdata);
  int n_to=0;
  initial {psel,penable,pwrite,paddr,pwdata}='0;
  task xfer(input logic w,input logic [11:0] a,input logic [31:0] d,output logic [31:0] r);
    @(posedge pclk);
    psel<=1;
    pwrite<=w;
    paddr<=a;
    pwdata<=d;
    @(posedge pclk);
    penable<=1;
    for(int k=0;k<1000;k++) begin
      @(posedge pclk);
      if(pready===1'b1) break;
      if(k==999) n_to++;
    end
    r=prdata;
    psel<=0;
    penable<=0;
  endtask : xfer
endmodule : aod_proc
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the channel registers
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import aod_pkg::*;
  logic pclk=0,presetn=0,psel,penable,pwrite,pready,pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata,prdata,r;
  aod_code_t c[4];
  int n_fail=0,cmp_count=0;
  aod_regs aod_regs_i(.pclk,.presetn,.psel,.penable,.pwrite,.paddr,.pwdata,.pstrb(4'hF),
    .prdata,.pready,.pslverr,.dac_code0(c[0]),.dac_code1(c[1]),.dac_code2(c[2]),
    .dac_code3(c[3]));
  aod_proc aod_proc_i(.pclk,.pready,.prdata,.psel,.penable,.pwrite,.paddr,.pwdata);
  initial forever #50 pclk=~pclk;
  task chk(input string n,input logic [31:0] e,input logic [31:0] s);
    cmp_count++;
    if(s!==e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h",n,e,s);
    end
  endtask : chk
  task t_regs;
    logic [15:0] v;
    for(int i=0;i<4;i++) begin
      v=16'h7001+16'h2345*i;
      aod_proc_i.xfer(1,12'(4*i),{16'hFFFF,v},r);
      @(negedge pclk);
      chk("code",32'({v[15],v[11:1]}),32'(c[i]));
      aod_proc_i.xfer(0,12'(4*i),0,r);
      chk("read",{16'h0,v[15:1],1'b0},r);
    end
    for(int i=0;i<4;i++) begin
      v=16'h7001+16'h2345*i;
      chk("hold",32'({v[15],v[11:1]}),32'(c[i]));
    end
  endtask : t_regs
  task t_err;
    logic [15:0] v;
    aod_proc_i.xfer(1,12'h010,32'h0000_FFFF,r);
    @(negedge pclk);
    chk("slverr",1,32'(pslverr));
    chk("ready",1,32'(pready));
    for(int i=0;i<4;i++) begin
      v=16'h7001+16'h2345*i;
      chk("keep",32'({v[15],v[11:1]}),32'(c[i]));
    end
    aod_proc_i.xfer(0,12'h010,0,r);
    chk("unmapped read",0,r);
  endtask : t_err
  task end_of_test;
    if(n_fail==0&&cmp_count>0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat(12) @(posedge pclk);
    presetn<=1;
    t_regs;
    t_err;
    chk("timeout",0,aod_proc_i.n_to);
    end_of_test;
  end
  initial begin
    repeat(2000) @(posedge pclk);
    n_fail++;
    end_of_test;
  end
endmodule : testbench
`default_nettype wire
